//--- bench/kbf_host_model.sv
// Host processor model issuing I/O cycles on the mailbox bus
`timescale 1ns/100ps
module kbf_host_model (
  input  wire logic        MCLK,
  input  wire logic [7:0]  SD_OUT,
  input  wire logic        SD_OE,
  output logic      [15:0] SA,
  output logic             AEN,
  output logic             IOR_N,
  output logic             IOW_N,
  output logic      [7:0]  SD_IN
);
  initial begin
    SA = 16'h0000;
    AEN = 1'b1;
    IOR_N = 1'b1;
    IOW_N = 1'b1;
    SD_IN = 8'h00;
  end

  // Address settles well ahead of the strobe, since the pins pass a synchroniser
  task automatic io(input logic [15:0] a, input logic [7:0] dat, input logic rd,
                    output logic [7:0] q, output logic oe);
    @(negedge MCLK);
    SA = a;
    AEN = 1'b0;
    SD_IN = rd ? ~SD_IN : dat;
    repeat (3) @(negedge MCLK);
    IOR_N = !rd;
    IOW_N = rd;
    repeat (7) @(negedge MCLK);
    q = SD_OUT;
    oe = SD_OE;
    IOR_N = 1'b1;
    IOW_N = 1'b1;
    // Address held until the clear at the read's trailing edge has landed
    repeat (6) @(negedge MCLK);
    AEN = 1'b1;
    SA = ~SA;
    SD_IN = ~SD_IN;
  endtask
endmodule // kbf_host_model

//--- bench/kbf_properties.sv
// Port-level checks for the mailbox flags and fast gate block
`timescale 1ns/100ps
module kbf_properties (
  input wire logic        MCLK,
  input wire logic        NRST,
  input wire logic [15:0] SA,
  input wire logic        AEN,
  input wire logic        IOW_N,
  input wire logic [7:0]  SD_OUT,
  input wire logic        SD_OE,
  input wire logic        CTRL_CLK_EN,
  input wire logic        CPU_RD_DATA,
  input wire logic        CPU_WR_DATA,
  input wire logic [7:0]  CPU_STATUS,
  input wire logic [3:0]  LINE_OE,
  input wire logic [7:0]  FASTGATE_CFG_REG,
  input wire logic        CTRL_GATE_PORT_BIT,
  input wire logic        CTRL_CPU_RESET_N,
  input wire logic        RESET_POLARITY,
  input wire logic        ALT_CPU_RESET_N,
  input wire logic        ALT_ADDR20_GATE,
  input wire logic        CPU_ADDR20_MASK_N,
  input wire logic        COMBINED_RESET_OUT
);
  logic [10:0] low_cnt;
  logic [12:0] wr_age;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  // Pulse length so far, and cycles since the last fast gate write (saturating)
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      low_cnt <= '0;
      wr_age <= '1;
    end else begin
      low_cnt <= ALT_CPU_RESET_N ? 11'h000 : low_cnt + 11'h001;
      wr_age <= ($fell(IOW_N) && !AEN && SA == kbf_pkg::ADDR_FASTGATE) ? 13'h0000
              : wr_age + {12'h000, wr_age != 13'h1fff};
    end
  end

  sequence s_host_wr(logic [15:0] a);
    $fell(IOW_N) && !AEN && SA == a;
  endsequence
  sequence s_cpu_take(logic strobe);
    strobe && CTRL_CLK_EN;
  endsequence

  a_cmd_flag: assert property (
    s_host_wr(kbf_pkg::ADDR_CMD) |-> ##[3:6] (CPU_STATUS[3] && CPU_STATUS[1]))
    else $error("command write flags wrong");
  a_data_flag: assert property (
    s_host_wr(kbf_pkg::ADDR_DATA) |-> ##[3:6] (!CPU_STATUS[3] && CPU_STATUS[1]))
    else $error("data write flags wrong");
  a_out_full_set: assert property (
    s_cpu_take(CPU_WR_DATA) |-> ##2 CPU_STATUS[0])
    else $error("output full not set");
  a_in_full_clear: assert property (
    s_cpu_take(CPU_RD_DATA) ##0 (IOW_N && $past(IOW_N) && $past(IOW_N, 2))
    |-> ##2 !CPU_STATUS[1])
    else $error("input full not cleared");
  a_mask_or: assert property (
    $past(NRST) |-> CPU_ADDR20_MASK_N == ($past(CTRL_GATE_PORT_BIT) | ALT_ADDR20_GATE))
    else $error("address mask not an or");
  a_comb_plain: assert property (
    $past(NRST) && !$past(FASTGATE_CFG_REG[2])
    |-> COMBINED_RESET_OUT == ($past(CTRL_CPU_RESET_N) ^ $past(RESET_POLARITY)))
    else $error("combined reset wrong while port off");
  a_comb_pulse: assert property (
    $past(FASTGATE_CFG_REG[2]) && !ALT_CPU_RESET_N && !$past(ALT_CPU_RESET_N)
    |-> COMBINED_RESET_OUT == $past(RESET_POLARITY))
    else $error("combined reset misses pulse");
  a_pulse_len: assert property (
    $rose(ALT_CPU_RESET_N) |-> low_cnt == 11'd1500)
    else $error("reset pulse length wrong");
  a_pulse_wait: assert property (
    $fell(ALT_CPU_RESET_N) |-> wr_age >= 13'd3500 && wr_age <= 13'd3512)
    else $error("reset pulse delay wrong");
  a_reset_idle: assert property (
    $rose(NRST) |-> ALT_CPU_RESET_N && !ALT_ADDR20_GATE && CPU_STATUS == 8'h00
      && LINE_OE == 4'h0 && !SD_OE)
    else $error("outputs not idle in reset");
  a_fg_fixed: assert property (
    SD_OE && $past(SD_OE) && SA == kbf_pkg::ADDR_FASTGATE |-> (SD_OUT & 8'hfc) == 8'h24)
    else $error("fast gate reserved bits wrong");
endmodule // kbf_properties

//--- bench/tb.sv
// Self-checking bench for the mailbox flags and fast gate block
`timescale 1ns/100ps
module tb;
  logic        MCLK, NRST, AEN, IOR_N, IOW_N, SD_OE, CTRL_CLK_EN;
  logic [15:0] SA;
  logic [7:0]  SD_IN, SD_OUT, CPU_DATA_IN, CPU_DATA_OUT, CPU_STATUS, FASTGATE_CFG_REG;
  logic        CPU_RD_DATA, CPU_WR_DATA, CPU_WR_STATUS, IBF_IRQ_EN, INPUT_FULL_IRQ_N;
  logic [3:0]  LINE_DRIVE, LINE_OE;
  logic        CTRL_GATE_PORT_BIT, CTRL_CPU_RESET_N, RESET_POLARITY;
  logic        ALT_CPU_RESET_N, ALT_ADDR20_GATE, CPU_ADDR20_MASK_N, COMBINED_RESET_OUT;
  int          num_errors, samples_checked, n;
  logic [31:0] seed;
  logic [7:0]  d, u, v;
  logic        oe;

  kbf_top i_kbf_top (.MCLK, .NRST, .SA, .AEN, .IOR_N, .IOW_N, .SD_IN, .SD_OUT, .SD_OE,
    .CTRL_CLK_EN, .CPU_RD_DATA, .CPU_WR_DATA, .CPU_WR_STATUS, .CPU_DATA_IN,
    .CPU_DATA_OUT, .CPU_STATUS, .IBF_IRQ_EN, .INPUT_FULL_IRQ_N, .LINE_DRIVE, .LINE_OE,
    .FASTGATE_CFG_REG, .CTRL_GATE_PORT_BIT, .CTRL_CPU_RESET_N, .RESET_POLARITY,
    .ALT_CPU_RESET_N, .ALT_ADDR20_GATE, .CPU_ADDR20_MASK_N, .COMBINED_RESET_OUT);
  kbf_host_model i_kbf_host_model (.MCLK, .SD_OUT, .SD_OE, .SA, .AEN, .IOR_N, .IOW_N,
    .SD_IN);

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] st_exp(input logic [7:0] usr, input logic cd, input_full_flag, output_full_flag);
    return (usr & 8'hf4) | {4'h0, cd, 1'b0, input_full_flag, output_full_flag};
  endfunction
  function automatic logic [7:0] fg_exp(input logic a20, rst);
    return 8'h24 | {6'h00, a20, rst};
  endfunction

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic guard(input logic hit);
    if (hit) begin
      num_errors++;
      summarize;
    end
  endtask
  task automatic roll;
    seed = xs(seed);
    d = seed[7:0];
    u = seed[15:8];
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] dat);
    i_kbf_host_model.io(a, dat, 1'b0, v, oe);
  endtask
  task automatic rd(input logic [15:0] a);
    i_kbf_host_model.io(a, 8'h00, 1'b1, v, oe);
  endtask
  // Strobe placed where the enable is already up, so exactly one edge takes it
  task automatic ctl(input logic [2:0] op, input logic [7:0] dat);
    n = 0;
    @(negedge MCLK);
    while (CTRL_CLK_EN !== 1'b1 && n < 50) begin
      @(negedge MCLK);
      n++;
    end
    guard(n == 50);
    {CPU_RD_DATA, CPU_WR_DATA, CPU_WR_STATUS} = op;
    CPU_DATA_IN = dat;
    @(negedge MCLK);
    {CPU_RD_DATA, CPU_WR_DATA, CPU_WR_STATUS} = 3'h0;
    CPU_DATA_IN = ~dat;
    repeat (3) @(negedge MCLK);
  endtask
  task automatic pulse;
    n = 0;
    while (ALT_CPU_RESET_N === 1'b1 && n < 4000) begin
      @(negedge MCLK);
      n++;
    end
    guard(n == 4000);
    chk(n + 13 >= 14000 / 4 && n <= 3500, 1);
    n = 0;
    while (ALT_CPU_RESET_N === 1'b0 && n < 2000) begin
      if (n == 700) chk(COMBINED_RESET_OUT, RESET_POLARITY);
      @(negedge MCLK);
      n++;
    end
    chk(n[15:0], 6000 / 4);
    $display("test alt reset pulse done");
  endtask

  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  initial begin
    seed = 32'h0000892f;
    NRST = 1'b0;
    {CPU_RD_DATA, CPU_WR_DATA, CPU_WR_STATUS, IBF_IRQ_EN} = 4'h0;
    CPU_DATA_IN = 8'h00;
    FASTGATE_CFG_REG = 8'h00;
    {CTRL_GATE_PORT_BIT, CTRL_CPU_RESET_N, RESET_POLARITY} = 3'h2;
    LINE_DRIVE = 4'hf;
    repeat (500) @(negedge MCLK);
    chk({ALT_CPU_RESET_N, ALT_ADDR20_GATE, LINE_OE}, 6'h20);
    chk(CPU_STATUS, 8'h00);
    NRST = 1'b1;
    roll;
    FASTGATE_CFG_REG = d & 8'hfb;
    {LINE_DRIVE, CTRL_CPU_RESET_N, RESET_POLARITY} = d[7:2];
    for (int k = 0; k < 6; k++) begin
      roll;
      if (k == 0) u = 8'hff;
      IBF_IRQ_EN = k[1];
      ctl(3'h1, u);
      wr(k[0] ? kbf_pkg::ADDR_CMD : kbf_pkg::ADDR_DATA, d);
      chk(CPU_DATA_OUT, d);
      chk(INPUT_FULL_IRQ_N, !k[1]);
      rd(kbf_pkg::ADDR_CMD);
      chk(v, st_exp(u, k[0], 1'b1, 1'b0));
      ctl(3'h4, 8'h00);
      chk(INPUT_FULL_IRQ_N, 1);
      ctl(3'h2, d ^ u);
      rd(kbf_pkg::ADDR_CMD);
      chk(v, st_exp(u, k[0], 1'b0, 1'b1));
      rd(kbf_pkg::ADDR_DATA);
      chk(v, d ^ u);
      rd(kbf_pkg::ADDR_CMD);
      chk(v, st_exp(u, k[0], 1'b0, 1'b0));
    end
    $display("test mailbox flags done");
    rd(kbf_pkg::ADDR_FASTGATE);
    chk(oe, 0);
    wr(kbf_pkg::ADDR_FASTGATE, 8'h03);
    chk(ALT_ADDR20_GATE, 0);
    chk(LINE_OE, LINE_DRIVE);
    FASTGATE_CFG_REG[2] = 1'b1;
    for (int i = 0; i < 4; i++) begin
      CTRL_GATE_PORT_BIT = i[0];
      wr(kbf_pkg::ADDR_FASTGATE, {6'h00, i[1], 1'b0});
      rd(kbf_pkg::ADDR_FASTGATE);
      chk(v, fg_exp(i[1], 1'b0));
      chk(CPU_ADDR20_MASK_N, i[0] | i[1]);
    end
    $display("test fast gate decode done");
    wr(kbf_pkg::ADDR_FASTGATE, 8'h03);
    pulse;
    rd(kbf_pkg::ADDR_FASTGATE);
    chk(v, fg_exp(1'b1, 1'b1));
    wr(kbf_pkg::ADDR_FASTGATE, 8'h03);
    n = 0;
    repeat (5000) begin
      @(negedge MCLK);
      if (ALT_CPU_RESET_N === 1'b0) n++;
    end
    chk(n[15:0], 0);
    wr(kbf_pkg::ADDR_FASTGATE, 8'h02);
    RESET_POLARITY = !RESET_POLARITY;
    wr(kbf_pkg::ADDR_FASTGATE, 8'h01);
    chk(ALT_ADDR20_GATE, 0);
    pulse;
    // system reset in mid-run clears bit 0, bit 1 and the status
    wr(kbf_pkg::ADDR_FASTGATE, 8'h03);
    NRST = 1'b0;
    repeat (500) @(negedge MCLK);
    chk(CPU_STATUS, 8'h00);
    chk(ALT_ADDR20_GATE, 0);
    NRST = 1'b1;
    rd(kbf_pkg::ADDR_FASTGATE);
    chk(v, fg_exp(1'b0, 1'b0));
    $display("test mid-run reset done");
    summarize;
  end
endmodule // tb

bind kbf_top kbf_properties i_kbf_properties (.MCLK, .NRST, .SA, .AEN, .IOW_N, .SD_OUT,
  .SD_OE, .CTRL_CLK_EN, .CPU_RD_DATA, .CPU_WR_DATA, .CPU_STATUS, .LINE_OE,
  .FASTGATE_CFG_REG, .CTRL_GATE_PORT_BIT, .CTRL_CPU_RESET_N, .RESET_POLARITY,
  .ALT_CPU_RESET_N, .ALT_ADDR20_GATE, .CPU_ADDR20_MASK_N, .COMBINED_RESET_OUT);

//--- core/kbf_pkg.sv
// Shared constants and types for the keyboard mailbox flags and fast gate block
package kbf_pkg;
  // Host I/O map
  localparam logic [15:0] ADDR_DATA      = 16'h0060;
  localparam logic [15:0] ADDR_CMD       = 16'h0064;
  localparam logic [15:0] ADDR_FASTGATE  = 16'h0092;
  localparam int          SA_CMD_BIT     = 2;
  // Status register layout
  localparam int          ST_OUT_FULL    = 0;
  localparam int          ST_IN_FULL     = 1;
  localparam int          ST_CMD_DATA    = 3;
  localparam logic [7:0]  ST_USER_MASK   = 8'hf4;
  localparam logic [7:0]  ST_RESET       = 8'h00;
  // Fast gate port layout
  localparam logic [7:0]  FG_RESET       = 8'h24;
  localparam logic [7:0]  FG_FIXED_MASK  = 8'hfc;
  localparam logic [7:0]  FG_FIXED_VAL   = 8'h24;
  localparam int          FG_A20_BIT     = 1;
  localparam int          FG_RST_BIT     = 0;
  localparam int          CFG_FG_EN_BIT  = 2;
  // Clocking
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          MCLK_KHZ       = 250000;
  localparam int          REF_CLK_KHZ    = 14318;
  localparam int          CTRL_CLK_KHZ   = 12000;
  localparam int          ACC_W          = 18;
  localparam int          RESET_MIN_CLKS = 24;
  // Alternate reset pulse; the longer figures also cover 500 ns / 1 us
  localparam int          ALT_DELAY_NS   = 14000;
  localparam int          ALT_LOW_NS     = 6000;
  localparam int          ALT_DELAY_CYC  = (ALT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ALT_LOW_CYC    = (ALT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PULSE_CNT_W    = 12;

  typedef enum logic [1:0] {PS_IDLE, PS_WAIT, PS_LOW} kbf_pulse_state_t;
endpackage

//--- core/kbf_pulse.sv
// Delayed low pulse generator for the alternate CPU reset
`timescale 1ns/100ps
module kbf_pulse #(
  parameter int DELAY_CYC = kbf_pkg::ALT_DELAY_CYC,
  parameter int LOW_CYC   = kbf_pkg::ALT_LOW_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      pulse_n
);
  kbf_pkg::kbf_pulse_state_t state;
  kbf_pkg::kbf_pulse_state_t next_state;
  logic [kbf_pkg::PULSE_CNT_W-1:0] cnt;
  logic [kbf_pkg::PULSE_CNT_W-1:0] next_cnt;
  wire logic cnt_zero = (cnt == '0);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      kbf_pkg::PS_IDLE: begin
        // Triggers while a pulse runs are ignored: one pulse per rise seen in idle
        if (trigger) begin
          next_state = kbf_pkg::PS_WAIT;
          next_cnt   = kbf_pkg::PULSE_CNT_W'(DELAY_CYC - 1);
        end
      end
      kbf_pkg::PS_WAIT: begin
        if (cnt_zero) begin
          next_state = kbf_pkg::PS_LOW;
          next_cnt   = kbf_pkg::PULSE_CNT_W'(LOW_CYC - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      kbf_pkg::PS_LOW: begin
        if (cnt_zero) begin
          next_state = kbf_pkg::PS_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = kbf_pkg::PS_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= kbf_pkg::PS_IDLE;
      cnt     <= '0;
      pulse_n <= 1'b1;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      pulse_n <= (next_state != kbf_pkg::PS_LOW);
    end
  end
endmodule // kbf_pulse

//--- core/kbf_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/100ps
module kbf_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // kbf_sync

//--- core/kbf_top.sv
// Keyboard mailbox host flags with fast A20 gate and alternate CPU reset
// What this block does
// - Status clears on reset; host reads, CPU writes.
// - User status bits hold CPU-written values.
// - Host write sets command flag from SA2.
// - Host write sets input-full flag and interrupt.
// - CPU data read clears input-full and interrupt.
// - CPU write sets output-full; host read clears.
// - Controller runs at 12 MHz rate.
// - Reset releases lines, clears status, keeps data.
// - Fast gate port decoded only when enabled.
// - Fast gate reserved bits read fixed values.
// - Bit 1 drives alternate A20, low after reset.
// - Bit 0 is read/write, cleared on reset.
// - Bit 0 rise: wait, then pulse reset low.
// - Pulse low 6 us after 14 us delay.
// - One pulse per bit 0 rise seen while idle; rises during a pulse ignored.
// - Alternate reset idles high after reset.
// - Combined reset is AND, polarity selectable.
// - A20 mask low only when both sources low.
// - Status bits: out-full 0, in-full 1, command 3.
`timescale 1ns/100ps
module kbf_top (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // Host I/O bus pins
  input  wire logic [15:0] SA,
  input  wire logic        AEN,
  input  wire logic        IOR_N,
  input  wire logic        IOW_N,
  input  wire logic [7:0]  SD_IN,
  output logic      [7:0]  SD_OUT,
  output logic             SD_OE,
  // Embedded controller side
  output logic             CTRL_CLK_EN,
  input  wire logic        CPU_RD_DATA,
  input  wire logic        CPU_WR_DATA,
  input  wire logic        CPU_WR_STATUS,
  input  wire logic [7:0]  CPU_DATA_IN,
  output logic      [7:0]  CPU_DATA_OUT,
  output logic      [7:0]  CPU_STATUS,
  input  wire logic        IBF_IRQ_EN,
  output logic             INPUT_FULL_IRQ_N,
  // Keyboard and aux lines: [3] kbd clock, [2] kbd data, [1] aux clock, [0] aux data
  input  wire logic [3:0]  LINE_DRIVE,
  output logic      [3:0]  LINE_OE,
  // Fast gate and reset
  input  wire logic [7:0]  FASTGATE_CFG_REG,
  input  wire logic        CTRL_GATE_PORT_BIT,
  input  wire logic        CTRL_CPU_RESET_N,
  input  wire logic        RESET_POLARITY,
  output logic             ALT_CPU_RESET_N,
  output logic             ALT_ADDR20_GATE,
  output logic             CPU_ADDR20_MASK_N,
  output logic             COMBINED_RESET_OUT
);

  function automatic logic addr_hit(input logic [15:0] a,
                                    input logic        aen,
                                    input logic [15:0] target);
    addr_hit = !aen && (a == target);
  endfunction

  // ------------------------------------------------------------------
  // Controller clock enable
  // ------------------------------------------------------------------
  logic [kbf_pkg::ACC_W-1:0] phase_acc;
  logic                      ce12;

  localparam logic [kbf_pkg::ACC_W-1:0] ACC_STEP =
    kbf_pkg::ACC_W'(kbf_pkg::CTRL_CLK_KHZ);
  localparam logic [kbf_pkg::ACC_W-1:0] ACC_WRAP =
    kbf_pkg::ACC_W'(kbf_pkg::MCLK_KHZ - kbf_pkg::CTRL_CLK_KHZ);

  wire logic acc_wrap = (phase_acc >= ACC_WRAP);
  wire logic [kbf_pkg::ACC_W-1:0] next_phase_acc =
    acc_wrap ? (phase_acc - ACC_WRAP) : (phase_acc + ACC_STEP);

  // 12 MHz enable
  // Fractional accumulator gives the exact average rate with 4 ns jitter
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      phase_acc <= '0;
      ce12      <= 1'b0;
    end else begin
      phase_acc <= next_phase_acc;
      ce12      <= acc_wrap;
    end
  end

  // ------------------------------------------------------------------
  // Host pin synchronisation
  // ------------------------------------------------------------------
  logic [15:0] sa_s;
  logic        aen_s;
  logic        ior_n_s;
  logic        iow_n_s;
  logic [7:0]  sd_s;
  logic        ior_n_d;
  logic        iow_n_d;

  // Address and data pass the same two stages as the strobes, so all stay aligned
  // strobes synchronised
  kbf_sync #(
    .W       (27),
    .RST_VAL ({16'h0000, 1'b1, 1'b1, 1'b1, 8'h00})
  ) u_host_sync (
    .clk   (MCLK),
    .rst_n (NRST),
    .d     ({SA, AEN, IOR_N, IOW_N, SD_IN}),
    .q     ({sa_s, aen_s, ior_n_s, iow_n_s, sd_s})
  );

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ior_n_d <= 1'b1;
      iow_n_d <= 1'b1;
    end else begin
      ior_n_d <= ior_n_s;
      iow_n_d <= iow_n_s;
    end
  end

  wire logic wr_start = iow_n_d && !iow_n_s;
  // Read side effects wait for the trailing edge, when the host has the byte
  wire logic rd_end   = !ior_n_d && ior_n_s;
  wire logic rd_act   = !ior_n_s;

  wire logic fg_en = FASTGATE_CFG_REG[kbf_pkg::CFG_FG_EN_BIT];

  wire logic hit_data = addr_hit(sa_s, aen_s, kbf_pkg::ADDR_DATA);
  wire logic hit_cmd  = addr_hit(sa_s, aen_s, kbf_pkg::ADDR_CMD);
  wire logic hit_fg   = fg_en && addr_hit(sa_s, aen_s, kbf_pkg::ADDR_FASTGATE);

  wire logic host_wr_mbox = wr_start && (hit_data || hit_cmd);
  wire logic host_wr_fg   = wr_start && hit_fg;
  wire logic host_rd_out  = rd_end && hit_data;

  // Controller accesses count only on the controller clock enable
  wire logic cpu_rd  = CPU_RD_DATA && ce12;
  wire logic cpu_wr  = CPU_WR_DATA && ce12;
  wire logic cpu_wst = CPU_WR_STATUS && ce12;

  // ------------------------------------------------------------------
  // Mailbox data and status
  // ------------------------------------------------------------------
  logic [7:0] in_data;
  logic [7:0] out_data;
  logic       out_full;
  logic       in_full;
  logic       cmd_flag;
  logic [7:0] user_bits;

  // data registers not reset
  // Contents are undefined until the first write after power-up
  always_ff @(posedge MCLK) begin
    if (host_wr_mbox) begin
      in_data <= sd_s;
    end
    if (cpu_wr) begin
      out_data <= CPU_DATA_IN;
    end
  end

  wire logic next_in_full  = host_wr_mbox || (in_full && !cpu_rd);
  wire logic next_out_full = cpu_wr || (out_full && !host_rd_out);

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      in_full  <= kbf_pkg::ST_RESET[kbf_pkg::ST_IN_FULL];
      out_full <= kbf_pkg::ST_RESET[kbf_pkg::ST_OUT_FULL];
    end else begin
      in_full  <= next_in_full;
      out_full <= next_out_full;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cmd_flag <= kbf_pkg::ST_RESET[kbf_pkg::ST_CMD_DATA];
    end else if (host_wr_mbox) begin
      cmd_flag <= sa_s[kbf_pkg::SA_CMD_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      user_bits <= kbf_pkg::ST_RESET & kbf_pkg::ST_USER_MASK;
    end else if (cpu_wst) begin
      user_bits <= CPU_DATA_IN & kbf_pkg::ST_USER_MASK;
    end
  end

  logic [7:0] status_word;
  always_comb begin
    status_word = user_bits;
    status_word[kbf_pkg::ST_OUT_FULL] = out_full;
    status_word[kbf_pkg::ST_IN_FULL]  = in_full;
    status_word[kbf_pkg::ST_CMD_DATA] = cmd_flag;
  end

  // ------------------------------------------------------------------
  // Fast gate port
  // ------------------------------------------------------------------
  logic a20_bit;
  logic rst_bit;
  logic rst_bit_d;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      a20_bit <= kbf_pkg::FG_RESET[kbf_pkg::FG_A20_BIT];
      rst_bit <= kbf_pkg::FG_RESET[kbf_pkg::FG_RST_BIT];
    end else if (host_wr_fg) begin
      a20_bit <= sd_s[kbf_pkg::FG_A20_BIT];
      rst_bit <= sd_s[kbf_pkg::FG_RST_BIT];
    end
  end

  // Previous bit 0, for the rising-edge trigger
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rst_bit_d <= kbf_pkg::FG_RESET[kbf_pkg::FG_RST_BIT];
    end else begin
      rst_bit_d <= rst_bit;
    end
  end

  logic [7:0] fg_word;
  always_comb begin
    fg_word = kbf_pkg::FG_FIXED_VAL & kbf_pkg::FG_FIXED_MASK;
    fg_word[kbf_pkg::FG_A20_BIT] = a20_bit;
    fg_word[kbf_pkg::FG_RST_BIT] = rst_bit;
  end

  // trigger only on rising bit 0
  wire logic alt_trig = rst_bit && !rst_bit_d;
  logic      alt_pulse_n;

  // 14 us delay, 6 us low
  // The long figures are used since they also meet the short minimums
  kbf_pulse #(
    .DELAY_CYC (kbf_pkg::ALT_DELAY_CYC),
    .LOW_CYC   (kbf_pkg::ALT_LOW_CYC)
  ) u_alt_pulse (
    .clk     (MCLK),
    .rst_n   (NRST),
    .trigger (alt_trig),
    .pulse_n (alt_pulse_n)
  );

  // AND with controller reset
  // With the port disabled its pulse must not reach the combined pin
  wire logic rst_and = fg_en ? (alt_pulse_n && CTRL_CPU_RESET_N) : CTRL_CPU_RESET_N;
  wire logic next_combined = RESET_POLARITY ? !rst_and : rst_and;

  // mask high if either source high
  wire logic next_mask_n = CTRL_GATE_PORT_BIT || a20_bit;

  // ------------------------------------------------------------------
  // Host read data
  // ------------------------------------------------------------------
  wire logic       rd_hit  = rd_act && (hit_data || hit_cmd || hit_fg);
  wire logic [7:0] rd_word = hit_data ? out_data :
                             hit_cmd  ? status_word : fg_word;

  // ------------------------------------------------------------------
  // Output registers, grouped by the side that reads them
  // ------------------------------------------------------------------
  // Host data bus
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      SD_OUT <= 8'h00;
      SD_OE  <= 1'b0;
    end else begin
      SD_OUT <= rd_word;
      SD_OE  <= rd_hit;
    end
  end

  // Exported enable is high in the very cycle that ce12 gates controller strobes
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CTRL_CLK_EN      <= 1'b0;
      CPU_DATA_OUT     <= 8'h00;
      CPU_STATUS       <= kbf_pkg::ST_RESET;
      INPUT_FULL_IRQ_N <= 1'b1;
    end else begin
      CTRL_CLK_EN      <= acc_wrap;
      CPU_DATA_OUT     <= in_data;
      CPU_STATUS       <= status_word;
      INPUT_FULL_IRQ_N <= !(next_in_full && IBF_IRQ_EN);
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      LINE_OE <= 4'h0;
    end else begin
      LINE_OE <= LINE_DRIVE;
    end
  end

  // Fast gate outputs
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ALT_CPU_RESET_N <= 1'b1;
      ALT_ADDR20_GATE <= 1'b0;
    end else begin
      ALT_CPU_RESET_N <= alt_pulse_n;
      ALT_ADDR20_GATE <= a20_bit;
    end
  end

  // Mask and reset pins toward the host processor
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CPU_ADDR20_MASK_N  <= 1'b0;
      COMBINED_RESET_OUT <= 1'b1;
    end else begin
      CPU_ADDR20_MASK_N  <= next_mask_n;
      COMBINED_RESET_OUT <= next_combined;
    end
  end

endmodule // kbf_top
